/* rtl/lcdcd_decoder.sv */
// command decoder and host bus end of the display driver
`timescale 1ns/1ps
module lcdcd_decoder
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic chipSelect_n,
    input wire logic cmdDataSelect,
    input wire logic readStrobe_n,
    input wire logic writeStrobe_n,
    input wire logic [7:0] busIn,
    output logic [7:0] busOut,
    output logic busOe_n,
    output logic panelOn,
    output logic [4:0] startLine,
    output logic [2:0] page,
    output logic [6:0] column,
    output logic segReverse,
    output logic staticDrive,
    output logic dutyHigh,
    output logic dutyPlusOne,
    output logic rmwMode,
    output logic [2:0] powerCtrl,
    output logic [4:0] contrast,
    output logic [4:0] lcdDriveVoltage,
    output logic clockStop,
    output logic powerSave,
    output logic displayClockOut
);
    logic [11:0] syncA;
    logic [11:0] syncB;
    logic csSync_n;
    logic a0Sync;
    logic rdSync_n;
    logic wrSync_n;
    logic [7:0] dataSync;
    logic rdPrev_n;
    logic wrPrev_n;
    logic heldA0;
    logic [7:0] heldByte;
    logic wrEnd;
    logic rdStart;
    logic rdEnd;
    logic cmdWr;
    logic dataWr;
    logic dataRd;
    logic [6:0] savedColumn;
    logic [7:0] ramData;
    logic [7:0] statusByte;
    logic [7:0] clkCount;
    logic powerSavePrev;
    logic isSoftReset;
    logic isColumn;
    logic isRmwEnter;
    logic isRmwEnd;

    // two flops on every pin input; only syncB is read by logic
    always_ff @(posedge mclk)
    begin
        syncA <= {chipSelect_n, cmdDataSelect, readStrobe_n, writeStrobe_n, busIn};
        syncB <= syncA;
    end
    assign csSync_n = syncB[11];
    assign a0Sync = syncB[10];
    assign rdSync_n = syncB[9];
    assign wrSync_n = syncB[8];
    assign dataSync = syncB[7:0];

    // strobe history; held byte and select track the bus while a strobe is low
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            rdPrev_n <= 1'b1;
            wrPrev_n <= 1'b1;
            heldA0 <= 1'b0;
            heldByte <= 8'h00;
        end
        else
        begin
            rdPrev_n <= rdSync_n | csSync_n;
            wrPrev_n <= wrSync_n | csSync_n;
            if (!csSync_n && (!wrSync_n || !rdSync_n))
            begin
                heldA0 <= a0Sync;
                heldByte <= dataSync;
            end
        end
    end

    // a write is taken on the rising end of its strobe
    assign wrEnd = !wrPrev_n && (wrSync_n || csSync_n);
    assign rdStart = rdPrev_n && !rdSync_n && !csSync_n;
    assign rdEnd = !rdPrev_n && (rdSync_n || csSync_n);
    assign cmdWr = wrEnd && !heldA0;
    assign dataWr = wrEnd && heldA0;
    assign dataRd = rdEnd && heldA0;
    assign isSoftReset = cmdWr && heldByte == lcdcd_pkg::OP_SOFT_RESET;
    assign isColumn = cmdWr && !heldByte[7];
    assign isRmwEnter = cmdWr && heldByte == lcdcd_pkg::OP_RMW_ENTER;
    assign isRmwEnd = cmdWr && heldByte == lcdcd_pkg::OP_RMW_END;

    // one-bit mode flags, each set from bit 0 of its opcode
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            panelOn <= 1'b0;
            segReverse <= 1'b0;
            staticDrive <= 1'b0;
            dutyHigh <= 1'b0;
            dutyPlusOne <= 1'b0;
            clockStop <= 1'b0;
        end
        else if (cmdWr)
        begin
            if (heldByte[7:1] == lcdcd_pkg::OP_DISPLAY)
                panelOn <= heldByte[0];
            if (heldByte[7:1] == lcdcd_pkg::OP_ADC)
                segReverse <= heldByte[0];
            if (heldByte[7:1] == lcdcd_pkg::OP_ALLON)
                staticDrive <= heldByte[0];
            if (heldByte[7:1] == lcdcd_pkg::OP_DUTY)
                dutyHigh <= heldByte[0];
            if (heldByte[7:1] == lcdcd_pkg::OP_DUTYPLUS)
                dutyPlusOne <= heldByte[0];
            if (heldByte[7:1] == lcdcd_pkg::OP_CLOCK)
                clockStop <= heldByte[0];
        end
    end

    // start line, page and contrast; soft reset wins over nothing else pending
    always_ff @(posedge mclk)
    begin
        if (srst || isSoftReset)
        begin
            startLine <= lcdcd_pkg::START_LINE_RST;
            page <= lcdcd_pkg::PAGE_RST;
            contrast <= lcdcd_pkg::CONTRAST_RST;
        end
        else if (cmdWr)
        begin
            if (heldByte[7:5] == lcdcd_pkg::OP_START_LINE)
                startLine <= heldByte[4:0];
            if (heldByte[7:3] == lcdcd_pkg::OP_PAGE)
                page <= heldByte[2:0];
            if (heldByte[7:5] == lcdcd_pkg::OP_CONTRAST)
                contrast <= heldByte[4:0];
        end
    end

    // power save is a combination, not an opcode
    assign powerSave = !panelOn && staticDrive;

    // power control; entry into power save clears it so software must reload
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            powerCtrl <= lcdcd_pkg::POWER_RST;
            powerSavePrev <= 1'b0;
        end
        else
        begin
            powerSavePrev <= powerSave;
            if (powerSave && !powerSavePrev)
                powerCtrl <= lcdcd_pkg::POWER_RST;
            else if (cmdWr && heldByte[7:3] == lcdcd_pkg::OP_POWER)
                powerCtrl <= heldByte[2:0];
        end
    end

    // drive level follows contrast only while the regulator runs
    always_ff @(posedge mclk)
    begin
        if (srst)
            lcdDriveVoltage <= lcdcd_pkg::CONTRAST_RST;
        else if (powerCtrl[lcdcd_pkg::PWR_REG_BIT])
            lcdDriveVoltage <= contrast;
        else
            lcdDriveVoltage <= lcdcd_pkg::CONTRAST_RST;
    end

    // read-modify-write flag and the column saved on entry
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            rmwMode <= 1'b0;
            savedColumn <= lcdcd_pkg::COLUMN_RST;
        end
        else if (isRmwEnter && !rmwMode)
        begin
            rmwMode <= 1'b1;
            savedColumn <= column;
        end
        else if (isRmwEnd)
            rmwMode <= 1'b0;
    end

    // column counter; a repeated enter keeps the first saved column
    always_ff @(posedge mclk)
    begin
        if (srst || isSoftReset)
            column <= lcdcd_pkg::COLUMN_RST;
        else if (isColumn)
            column <= heldByte[6:0];
        else if (isRmwEnd && rmwMode)
            column <= savedColumn;
        else if (dataWr || (dataRd && !rmwMode))
            column <= column + 7'h01;
    end

    // memory: writes land on the strobe end at current page and column
    lcdcd_ram u_ram
    (
        .mclk(mclk),
        .writeEn(dataWr),
        .addr({page, column}),
        .writeData(heldByte),
        .readData(ramData)
    );

    // status: busy never set since every command completes in one cycle
    always_comb
    begin
        statusByte = 8'h00;
        statusByte[lcdcd_pkg::STAT_ADC_BIT] = segReverse;
        statusByte[lcdcd_pkg::STAT_OFF_BIT] = !panelOn;
    end

    // read data is frozen at the start of the strobe
    always_ff @(posedge mclk)
    begin
        if (srst)
            busOut <= 8'h00;
        else if (rdStart)
            busOut <= a0Sync ? ramData : statusByte;
    end

    // drive the bus for the whole read strobe, one cycle after its start
    always_ff @(posedge mclk)
    begin
        if (srst)
            busOe_n <= 1'b1;
        else if (rdStart)
            busOe_n <= 1'b0;
        else if (rdEnd)
            busOe_n <= 1'b1;
    end

    // display clock divider; held low when stopped or in power save
    always_ff @(posedge mclk)
    begin
        if (srst || clockStop || powerSave)
        begin
            clkCount <= 8'h00;
            displayClockOut <= 1'b0;
        end
        else if (clkCount == lcdcd_pkg::CLK_HALF_CYCLES - 8'h01)
        begin
            clkCount <= 8'h00;
            displayClockOut <= !displayClockOut;
        end
        else
            clkCount <= clkCount + 8'h01;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence seqCmd(logic [7:0] op);
        cmdWr && heldByte == op;
    endsequence

    sequence seqRmwEnd;
        rmwMode && isRmwEnd;
    endsequence

    chk_panel_enable: assert property (cmdWr && heldByte[7:1] == 7'h57 |=> panelOn == $past(heldByte[0]))
        else $error("panel enable not taken");
    chk_start_line: assert property (cmdWr && heldByte[7:5] == 3'h6 |=> startLine == $past(heldByte[4:0]))
        else $error("start line not loaded");
    chk_page_load: assert property (cmdWr && heldByte[7:3] == 5'h17 |=> page == $past(heldByte[2:0]))
        else $error("page not loaded");
    chk_column_load: assert property (isColumn |=> column == $past(heldByte[6:0]))
        else $error("column not loaded");
    chk_status_low: assert property (rdStart && !a0Sync |=> busOut[2:0] == 3'h0 ##1 !busOe_n)
        else $error("status low bits not zero");
    chk_column_step: assert property (dataWr && !isColumn |=> column == $past(column) + 7'h01)
        else $error("column did not advance");
    chk_rmw_hold: assert property (dataRd && rmwMode |=> column == $past(column))
        else $error("column moved on read in rmw");
    chk_rmw_restore: assert property (seqRmwEnd |=> column == $past(savedColumn) && !rmwMode)
        else $error("column not restored");
    chk_soft_reset: assert property (seqCmd(8'hE2) |=> column == 7'h00 && page == 3'h0 && contrast == 5'h00)
        else $error("soft reset incomplete");
    chk_save_entry: assert property ($rose(powerSave) |=> powerCtrl == 3'h0 && !displayClockOut)
        else $error("power save entry wrong");
    chk_drive_gate: assert property (!powerCtrl[1] |=> lcdDriveVoltage == 5'h00)
        else $error("drive level without regulator");
    chk_clock_stop: assert property (clockStop ##1 clockStop |-> !displayClockOut)
        else $error("display clock runs while stopped");
endmodule // lcdcd_decoder

/* rtl/lcdcd_pkg.sv */
// constants for the display driver command decoder
// Summary of operation
// - AEh/AFh set panel enable from bit 0
// - 110xxxxx loads start line register
// - 10111xxx loads page register
// - 0xxxxxxx loads column address counter
// - status read, low three bits zero
// - data write stores byte at page/column
// - data read returns byte at page/column
// - A0h/A1h select segment mapping direction
// - A4h/A5h normal or all pixels on
// - A8h/A9h select lower or higher duty
// - AAh/ABh add one common line
// - E0h/EEh enter/leave read-modify-write mode
// - 10110xxx loads power control register
// - 100xxxxx loads contrast register
// - E6h/E7h run or stop display clock
// - power save: panel off with static drive
// - leaving read-modify-write restores saved column
// - E2h resets start, column, page, contrast
// - power save stops clock, clears power control
// - contrast acts only with regulator enabled
package lcdcd_pkg;
    localparam logic [6:0] OP_DISPLAY = 7'h57;
    localparam logic [6:0] OP_ADC = 7'h50;
    localparam logic [6:0] OP_ALLON = 7'h52;
    localparam logic [6:0] OP_DUTY = 7'h54;
    localparam logic [6:0] OP_DUTYPLUS = 7'h55;
    localparam logic [6:0] OP_CLOCK = 7'h73;
    localparam logic [7:0] OP_RMW_ENTER = 8'hE0;
    localparam logic [7:0] OP_RMW_END = 8'hEE;
    localparam logic [7:0] OP_SOFT_RESET = 8'hE2;
    localparam logic [2:0] OP_START_LINE = 3'h6;
    localparam logic [4:0] OP_PAGE = 5'h17;
    localparam logic [4:0] OP_POWER = 5'h16;
    localparam logic [2:0] OP_CONTRAST = 3'h4;
    // field positions
    localparam int STAT_ADC_BIT = 6;
    localparam int STAT_OFF_BIT = 5;
    localparam int PWR_REG_BIT = 1;
    // values after reset
    localparam logic [4:0] START_LINE_RST = 5'h00;
    localparam logic [2:0] PAGE_RST = 3'h0;
    localparam logic [6:0] COLUMN_RST = 7'h00;
    localparam logic [4:0] CONTRAST_RST = 5'h00;
    localparam logic [2:0] POWER_RST = 3'h0;
    // display clock: half period in mclk cycles
    localparam logic [7:0] CLK_HALF_CYCLES = 8'h40;
endpackage

/* rtl/lcdcd_ram.sv */
// display memory: eight pages of 128 byte columns, synchronous read
`timescale 1ns/1ps
module lcdcd_ram
(
    input wire logic mclk,
    input wire logic writeEn,
    input wire logic [9:0] addr,
    input wire logic [7:0] writeData,
    output logic [7:0] readData
);
    logic [7:0] mem [0:1023];

    // read every cycle so data is ready when a read strobe arrives
    always_ff @(posedge mclk)
    begin
        if (writeEn)
        begin
            mem[addr] <= writeData;
        end
        readData <= mem[addr];
    end
endmodule // lcdcd_ram

/* test/lcdcd_decoder_tb.sv */
// self-checking bench for the display driver command decoder
`timescale 1ns/1ps
module lcdcd_decoder_tb;
    logic mclk, srst, chipSelect_n, cmdDataSelect, readStrobe_n, writeStrobe_n, busOe_n, panelOn, segReverse;
    logic staticDrive, dutyHigh, dutyPlusOne, rmwMode, clockStop, powerSave, displayClockOut, oe;
    logic [7:0] busIn, busOut, rdata;
    logic [4:0] startLine, contrast, lcdDriveVoltage;
    logic [2:0] page, powerCtrl;
    logic [6:0] column;
    int errors, checks, n;
    logic [7:0] toggleOps [5] = '{8'hA0, 8'hA4, 8'hA8, 8'hAA, 8'hE6};
    lcdcd_decoder u_lcdcd_decoder (.mclk(mclk), .srst(srst), .chipSelect_n(chipSelect_n),
        .cmdDataSelect(cmdDataSelect), .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n),
        .busIn(busIn), .busOut(busOut), .busOe_n(busOe_n), .panelOn(panelOn), .startLine(startLine),
        .page(page), .column(column), .segReverse(segReverse), .staticDrive(staticDrive),
        .dutyHigh(dutyHigh), .dutyPlusOne(dutyPlusOne), .rmwMode(rmwMode), .powerCtrl(powerCtrl),
        .contrast(contrast), .lcdDriveVoltage(lcdDriveVoltage), .clockStop(clockStop),
        .powerSave(powerSave), .displayClockOut(displayClockOut));
    lcdcd_host u_lcdcd_host (.mclk(mclk), .busOut(busOut), .busOe_n(busOe_n), .chipSelect_n(chipSelect_n),
        .cmdDataSelect(cmdDataSelect), .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n),
        .busIn(busIn));
    // 200 MHz clock
    initial mclk = 1'b0;
    always #2.5 mclk = ~mclk;
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic checkVal(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic sel, input logic [7:0] d);
        u_lcdcd_host.writeByte(sel, d);
    endtask
    task automatic rd(input logic sel);
        u_lcdcd_host.readByte(sel, rdata, oe);
        checkVal({7'h00, oe}, 8'h00, "bus driven during read");
    endtask
    // edges of the display clock over 300 cycles, longer than its half period
    task automatic countToggles();
        logic last;
        n = 0;
        last = displayClockOut;
        repeat (300)
        begin
            @(negedge mclk);
            if (displayClockOut !== last)
                n++;
            last = displayClockOut;
        end
    endtask
    function automatic logic modeFlag(input int i);
        case (i)
            0: return segReverse;
            1: return staticDrive;
            2: return dutyHigh;
            3: return dutyPlusOne;
            default: return clockStop;
        endcase
    endfunction
    // main sequence
    initial
    begin
        errors = 0;
        checks = 0;
        srst = 1'b1;
        repeat (20) @(negedge mclk);
        srst = 1'b0;
        checkVal({7'h00, panelOn}, 8'h00, "panel after reset");
        checkVal({7'h00, busOe_n}, 8'h01, "bus released after reset");
        wr(1'b0, 8'hAF);
        checkVal({7'h00, panelOn}, 8'h01, "panel on");
        wr(1'b0, 8'hD5);
        checkVal({3'h0, startLine}, 8'h15, "start line");
        wr(1'b0, 8'hBD);
        checkVal({5'h00, page}, 8'h05, "page");
        wr(1'b0, 8'h7F);
        checkVal({1'b0, column}, 8'h7F, "column");
        for (int i = 0; i < 5; i++)
            for (int d = 0; d < 2; d++)
            begin
                wr(1'b0, toggleOps[i] | 8'(d));
                checkVal({7'h00, modeFlag(i)}, 8'(d), "mode flag");
            end
        $display("test commands done");
        wr(1'b0, 8'hBA);
        wr(1'b1, 8'h3C);
        checkVal({1'b0, column}, 8'h00, "column wraps after write");
        wr(1'b1, 8'hC5);
        wr(1'b0, 8'h7F);
        rd(1'b1);
        checkVal(rdata, 8'h3C, "data read");
        checkVal({1'b0, column}, 8'h00, "column after read");
        rd(1'b1);
        checkVal(rdata, 8'hC5, "second data read");
        $display("test data done");
        wr(1'b0, 8'h0A);
        wr(1'b0, 8'hE0);
        checkVal({7'h00, rmwMode}, 8'h01, "rmw entered");
        rd(1'b1);
        checkVal({1'b0, column}, 8'h0A, "no advance on rmw read");
        wr(1'b1, 8'h5A);
        checkVal({1'b0, column}, 8'h0B, "advance on rmw write");
        wr(1'b0, 8'hEE);
        checkVal({1'b0, column}, 8'h0A, "column restored");
        checkVal({7'h00, rmwMode}, 8'h00, "rmw left");
        rd(1'b0);
        checkVal(rdata, 8'h40, "status");
        $display("test rmw and status done");
        wr(1'b0, 8'hB7);
        checkVal({5'h00, powerCtrl}, 8'h07, "power control");
        wr(1'b0, 8'h93);
        checkVal({3'h0, contrast}, 8'h13, "contrast");
        checkVal({3'h0, lcdDriveVoltage}, 8'h13, "drive level with regulator");
        wr(1'b0, 8'hB5);
        checkVal({3'h0, lcdDriveVoltage}, 8'h00, "drive level without regulator");
        countToggles();
        checkVal(8'(n), 8'h00, "display clock stopped");
        wr(1'b0, 8'hE6);
        countToggles();
        checkVal({7'h00, n > 0}, 8'h01, "display clock running");
        wr(1'b0, 8'hA5);
        wr(1'b0, 8'hAE);
        checkVal({7'h00, powerSave}, 8'h01, "power save entered");
        checkVal({5'h00, powerCtrl}, 8'h00, "power control cleared");
        checkVal({7'h00, segReverse}, 8'h01, "modes kept in power save");
        countToggles();
        checkVal(8'(n), 8'h00, "display clock held low");
        checkVal({7'h00, displayClockOut}, 8'h00, "display clock level");
        rd(1'b0);
        checkVal(rdata, 8'h60, "status with panel off");
        wr(1'b0, 8'hAF);
        checkVal({7'h00, powerSave}, 8'h00, "power save left");
        $display("test power done");
        wr(1'b0, 8'hB7);
        wr(1'b0, 8'hE2);
        checkVal({3'h0, startLine}, 8'h00, "start line reset");
        checkVal({5'h00, page}, 8'h00, "page reset");
        checkVal({1'b0, column}, 8'h00, "column reset");
        checkVal({3'h0, contrast}, 8'h00, "contrast reset");
        checkVal({5'h00, powerCtrl}, 8'h07, "power control kept");
        checkVal({7'h00, segReverse}, 8'h01, "mapping kept");
        $display("test soft reset done");
        tally_and_finish();
    end
endmodule // lcdcd_decoder_tb

/* test/lcdcd_host.sv */
// host bus model: drives command and data transfers into the display driver
`timescale 1ns/1ps
module lcdcd_host
(
    input wire logic mclk,
    input wire logic [7:0] busOut,
    input wire logic busOe_n,
    output logic chipSelect_n,
    output logic cmdDataSelect,
    output logic readStrobe_n,
    output logic writeStrobe_n,
    output logic [7:0] busIn
);
    logic [7:0] hostData;
    // shared data wire: the device wins while it drives, else the host value
    assign busIn = busOe_n ? hostData : busOut;
    // idle bus, strobes released
    initial
    begin
        chipSelect_n = 1'b1;
        cmdDataSelect = 1'b0;
        readStrobe_n = 1'b1;
        writeStrobe_n = 1'b1;
        hostData = 8'h00;
    end
    task automatic pause(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // strobe phases of 4 cycles, the synchronisers need 3; only listed codes are sent
    task automatic writeByte(input logic sel, input logic [7:0] data);
        pause(1);
        chipSelect_n = 1'b0;
        cmdDataSelect = sel;
        hostData = data;
        writeStrobe_n = 1'b0;
        pause(4);
        writeStrobe_n = 1'b1;
        pause(4);
        chipSelect_n = 1'b1;
        hostData = ~data; // released data no longer shows the byte
        pause(3);
    endtask
    // data is taken late in the strobe, after the device has turned the bus
    task automatic readByte(input logic sel, output logic [7:0] data, output logic oe_n);
        pause(1);
        chipSelect_n = 1'b0;
        cmdDataSelect = sel;
        readStrobe_n = 1'b0;
        pause(6);
        data = busIn;
        oe_n = busOe_n;
        readStrobe_n = 1'b1;
        pause(4);
        chipSelect_n = 1'b1;
        pause(3);
    endtask
endmodule // lcdcd_host
